//--- hw/dtc_pkg.sv
// Package for the dual timer/counter: register map, fields, modes, counting
`default_nettype none

package dtc_pkg;

   // Machine cycle timing: six processor clocks of two oscillator periods
   localparam int unsigned CPU_CLKS_PER_MC  = 6;
   localparam int unsigned OSC_PER_CPU_CLK  = 2;
   localparam int unsigned MC_OSC_CLKS      = CPU_CLKS_PER_MC * OSC_PER_CPU_CLK;
   localparam int unsigned MC_CNT_W         = 4;
   localparam logic [MC_CNT_W-1:0] MC_LAST  = MC_CNT_W'(MC_OSC_CLKS - 1);

   // Avalon-MM register map, byte addresses
   localparam int unsigned ADDR_W           = 5;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] REG_MODE   = 5'h04;
   localparam logic [ADDR_W-1:0] REG_U0_LO  = 5'h08;
   localparam logic [ADDR_W-1:0] REG_U0_HI  = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_U1_LO  = 5'h10;
   localparam logic [ADDR_W-1:0] REG_U1_HI  = 5'h14;

   // timer_control fields
   localparam int unsigned CTRL_TF1 = 7;
   localparam int unsigned CTRL_TR1 = 6;
   localparam int unsigned CTRL_TF0 = 5;
   localparam int unsigned CTRL_TR0 = 4;
   localparam int unsigned CTRL_IE1 = 3;
   localparam int unsigned CTRL_IT1 = 2;
   localparam int unsigned CTRL_IE0 = 1;
   localparam int unsigned CTRL_IT0 = 0;

   // timer_mode fields
   localparam int unsigned MODE_GATE1 = 7;
   localparam int unsigned MODE_CT1   = 6;
   localparam int unsigned MODE_U1_HI = 5;
   localparam int unsigned MODE_U1_LO = 4;
   localparam int unsigned MODE_GATE0 = 3;
   localparam int unsigned MODE_CT0   = 2;
   localparam int unsigned MODE_U0_HI = 1;
   localparam int unsigned MODE_U0_LO = 0;

   // Reset values
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] MODE_RESET  = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;

   // Counter widths and limits
   localparam int unsigned  PRESCALE_W   = 5;
   localparam logic [4:0]   PRESCALE_MAX = 5'h1f;
   localparam logic [7:0]   BYTE_MAX     = 8'hff;
   localparam logic [15:0]  WORD_MAX     = 16'hffff;

   typedef enum logic [1:0]
   {
      DTC_MODE_13BIT  = 2'b00,
      DTC_MODE_16BIT  = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT  = 2'b11
   } dtc_mode_t;

   typedef enum logic
   {
      DTC_BUS_IDLE = 1'b0,
      DTC_BUS_DONE = 1'b1
   } dtc_bus_state_t;

   // Counter bytes with the overflow strobe of one step
   typedef struct packed
   {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } dtc_cnt_t;

   // One counting step of a unit; split mode only advances the low byte
   function automatic dtc_cnt_t dtc_cnt_step
   (
      input dtc_mode_t  mode,
      input logic [7:0] hi,
      input logic [7:0] lo,
      input logic       inc
   );
      dtc_cnt_t r;
      r.hi  = hi;
      r.lo  = lo;
      r.ovf = 1'b0;
      if (inc)
      begin
         case (mode)
            DTC_MODE_13BIT:
            begin
               if (lo[PRESCALE_W-1:0] == PRESCALE_MAX)
               begin
                  r.lo  = {lo[7:PRESCALE_W], {PRESCALE_W{1'b0}}};
                  r.hi  = hi + 8'h01;
                  r.ovf = (hi == BYTE_MAX);
               end
               else
               begin
                  r.lo = {lo[7:PRESCALE_W], lo[PRESCALE_W-1:0] + 5'h01};
               end
            end
            DTC_MODE_16BIT:
            begin
               {r.hi, r.lo} = {hi, lo} + 16'h0001;
               r.ovf        = ({hi, lo} == WORD_MAX);
            end
            DTC_MODE_RELOAD:
            begin
               r.lo  = (lo == BYTE_MAX) ? hi : lo + 8'h01;
               r.ovf = (lo == BYTE_MAX);
            end
            DTC_MODE_SPLIT:
            begin
               r.lo  = lo + 8'h01;
               r.ovf = (lo == BYTE_MAX);
            end
            default:
            begin
               r.lo = lo;
            end
         endcase
      end
      return r;
   endfunction

endpackage

`default_nettype wire

//--- hw/dtc_timer.sv
// Dual 16-bit timer/event counter with four modes and an Avalon-MM slave
`default_nettype none

// Contract
// - Timer function counts once per machine cycle
// - Counter samples pin per cycle, counts falls
// - Counted edge appears in the following cycle
// - Edge detection spans two cycles, rate limited
// - Selector bit picks machine cycle or pin
// - Two-bit field selects one of four modes
// - Mode 0: 13 bits, five-bit low prescaler
// - Rollover to zero sets the overflow flag
// - Count only when run and gate allow
// - Setting run bit keeps the count value
// - Mode 1: full 16-bit cascade, no prescaler
// - Mode 2: low byte reloads from high byte
// - Unit 1 mode 3 holds its count
// - Unit 0 split low byte uses unit 0 controls
// - Split high byte times, uses unit 1 bits
// - Unit 1 keeps counting without interrupt then
// - Overflow flags clear when vector taken
// - Run bits are software read/write
// - Edge flags set on pin edge, cleared processed
// - Type bits choose edge or level trigger
module dtc_timer
   import dtc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   input  wire logic              unit0_count_pin,
   input  wire logic              unit1_count_pin,
   input  wire logic              ext_irq0_pin_n,
   input  wire logic              ext_irq1_pin_n,
   input  wire logic              unit0_vector_ack,
   input  wire logic              unit1_vector_ack,
   input  wire logic              ext_irq0_vector_ack,
   input  wire logic              ext_irq1_vector_ack,
   output logic                   unit0_overflow_flag,
   output logic                   unit1_overflow_flag,
   output logic                   ext_irq0_edge_flag,
   output logic                   ext_irq1_edge_flag,
   output logic                   unit1_overflow_pulse
);

   logic [MC_CNT_W-1:0] mc_cnt;
   logic [7:0]          timer_control;
   logic [7:0]          timer_mode;
   logic [7:0]          unit0_low_byte;
   logic [7:0]          unit0_high_byte;
   logic [7:0]          unit1_low_byte;
   logic [7:0]          unit1_high_byte;
   logic [1:0]          cnt_smp;
   logic [1:0]          cnt_pend;
   logic [1:0]          irq_smp;
   dtc_bus_state_t      bus_state;
   dtc_bus_state_t      next_bus_state;

   // Machine cycle strobe: one core_clk in twelve
   wire logic mc_tick = (mc_cnt == MC_LAST);
   wire logic [MC_CNT_W-1:0] next_mc_cnt =
      mc_tick ? '0 : mc_cnt + MC_CNT_W'(1);

   // Bus slave: one wait cycle, then the request is taken
   wire logic bus_req = read | write;
   wire logic bus_take = bus_req & (bus_state == DTC_BUS_DONE);
   wire logic bus_wr = write & bus_take & byteenable[0];
   wire logic [7:0] wbyte = writedata[7:0];

   wire logic wr_ctrl = bus_wr & (address == REG_CTRL);
   wire logic wr_mode = bus_wr & (address == REG_MODE);
   wire logic wr_u0lo = bus_wr & (address == REG_U0_LO);
   wire logic wr_u0hi = bus_wr & (address == REG_U0_HI);
   wire logic wr_u1lo = bus_wr & (address == REG_U1_LO);
   wire logic wr_u1hi = bus_wr & (address == REG_U1_HI);

   wire logic [7:0] read_mux =
      (address == REG_CTRL)  ? timer_control   :
      (address == REG_MODE)  ? timer_mode      :
      (address == REG_U0_LO) ? unit0_low_byte  :
      (address == REG_U0_HI) ? unit0_high_byte :
      (address == REG_U1_LO) ? unit1_low_byte  :
      (address == REG_U1_HI) ? unit1_high_byte : 8'h00;

   always_comb
   begin
      case (bus_state)
         DTC_BUS_IDLE: next_bus_state = bus_req ? DTC_BUS_DONE : DTC_BUS_IDLE;
         DTC_BUS_DONE: next_bus_state = DTC_BUS_IDLE;
         default:      next_bus_state = DTC_BUS_IDLE;
      endcase
   end

   assign waitrequest = bus_req & (bus_state != DTC_BUS_DONE);

   // Mode fields
   wire dtc_mode_t u0_mode =
      dtc_mode_t'(timer_mode[MODE_U0_HI:MODE_U0_LO]);
   wire dtc_mode_t u1_mode =
      dtc_mode_t'(timer_mode[MODE_U1_HI:MODE_U1_LO]);
   wire logic u0_split = (u0_mode == DTC_MODE_SPLIT);
   wire logic u1_stop  = (u1_mode == DTC_MODE_SPLIT);

   // Pin falls seen across two machine-cycle samples, counted next cycle
   wire logic [1:0] cnt_pins = {unit1_count_pin, unit0_count_pin};
   wire logic [1:0] next_cnt_pend = cnt_smp & ~cnt_pins;

   // Count sources: machine cycle or pending pin fall
   wire logic u0_src = mc_tick &
      (timer_mode[MODE_CT0] ? cnt_pend[0] : 1'b1);
   wire logic u1_src = mc_tick &
      (timer_mode[MODE_CT1] ? cnt_pend[1] : 1'b1);

   // Gating by run bit and, when gate is set, by a high interrupt pin
   wire logic u0_gate_ok = ~timer_mode[MODE_GATE0] | ext_irq0_pin_n;
   wire logic u1_gate_ok = ~timer_mode[MODE_GATE1] | ext_irq1_pin_n;
   wire logic u0_inc = timer_control[CTRL_TR0] & u0_gate_ok & u0_src;

   // With unit 0 split, unit 1 loses its run bit and runs unless in mode 3
   wire logic u1_run = u0_split | timer_control[CTRL_TR1];
   wire logic u1_inc = ~u1_stop & u1_run & u1_gate_ok & u1_src;

   // Split high byte: machine cycles only, started by unit 1 run bit
   wire logic th0_inc = u0_split & timer_control[CTRL_TR1] & mc_tick;
   wire logic th0_ovf = th0_inc & (unit0_high_byte == BYTE_MAX);

   wire dtc_cnt_t u0_step = dtc_cnt_step(u0_mode, unit0_high_byte,
      unit0_low_byte, u0_inc);
   wire dtc_cnt_t u1_step = dtc_cnt_step(u1_mode, unit1_high_byte,
      unit1_low_byte, u1_inc);

   // Count bytes: a software write wins over counting in the same cycle
   wire logic [7:0] u0_hi_cnt =
      u0_split ? unit0_high_byte + {7'h00, th0_inc} : u0_step.hi;
   wire logic [7:0] next_u0_lo = wr_u0lo ? wbyte : u0_step.lo;
   wire logic [7:0] next_u0_hi = wr_u0hi ? wbyte : u0_hi_cnt;
   wire logic [7:0] next_u1_lo = wr_u1lo ? wbyte : u1_step.lo;
   wire logic [7:0] next_u1_hi = wr_u1hi ? wbyte : u1_step.hi;

   // Overflow events; unit 1 sets no flag of its own while unit 0 is split, only its overflow pulse
   wire logic tf0_set = u0_step.ovf;
   wire logic tf1_set = u0_split ? th0_ovf : u1_step.ovf;

   // External interrupt pins, sampled each machine cycle
   wire logic [1:0] irq_pins = {ext_irq1_pin_n, ext_irq0_pin_n};
   wire logic [1:0] irq_type =
      {timer_control[CTRL_IT1], timer_control[CTRL_IT0]};
   wire logic [1:0] irq_fall = {2{mc_tick}} & irq_smp & ~irq_pins;
   wire logic [1:0] irq_low  = {2{mc_tick}} & ~irq_pins;
   wire logic [1:0] ie_set =
      (irq_type & irq_fall) | (~irq_type & irq_low);

   // Control register: software bits follow writes, flags set-over-clear
   wire logic [7:0] ctrl_base = wr_ctrl ? wbyte : timer_control;
   wire logic [7:0] ctrl_clr = {unit1_vector_ack, 1'b0, unit0_vector_ack,
      1'b0, ext_irq1_vector_ack, 1'b0, ext_irq0_vector_ack, 1'b0};
   wire logic [7:0] ctrl_set = {tf1_set, 1'b0, tf0_set, 1'b0,
      ie_set[1], 1'b0, ie_set[0], 1'b0};
   wire logic [7:0] next_timer_control = (ctrl_base & ~ctrl_clr) | ctrl_set;
   wire logic [7:0] next_timer_mode = wr_mode ? wbyte : timer_mode;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mc_cnt    <= '0;
         bus_state <= DTC_BUS_IDLE;
         readdata  <= '0;
      end
      else
      begin
         mc_cnt    <= next_mc_cnt;
         bus_state <= next_bus_state;
         if (read & (bus_state == DTC_BUS_IDLE))
         begin
            readdata <= {24'h000000, read_mux};
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         timer_control <= CTRL_RESET;
         timer_mode    <= MODE_RESET;
      end
      else
      begin
         timer_control <= next_timer_control;
         timer_mode    <= next_timer_mode;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         unit0_low_byte  <= COUNT_RESET;
         unit0_high_byte <= COUNT_RESET;
         unit1_low_byte  <= COUNT_RESET;
         unit1_high_byte <= COUNT_RESET;
      end
      else
      begin
         unit0_low_byte  <= next_u0_lo;
         unit0_high_byte <= next_u0_hi;
         unit1_low_byte  <= next_u1_lo;
         unit1_high_byte <= next_u1_hi;
      end
   end

   // Samples start high so no false fall is seen after reset
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_smp  <= 2'h3;
         cnt_pend <= 2'h0;
         irq_smp  <= 2'h3;
      end
      else if (mc_tick)
      begin
         cnt_smp  <= cnt_pins;
         cnt_pend <= next_cnt_pend;
         irq_smp  <= irq_pins;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         unit1_overflow_pulse <= 1'b0;
      end
      else
      begin
         unit1_overflow_pulse <= u1_step.ovf;
      end
   end

   assign unit0_overflow_flag = timer_control[CTRL_TF0];
   assign unit1_overflow_flag = timer_control[CTRL_TF1];
   assign ext_irq0_edge_flag  = timer_control[CTRL_IE0];
   assign ext_irq1_edge_flag  = timer_control[CTRL_IE1];

endmodule // dtc_timer

`default_nettype wire

//--- bench/dtc_timer_sva.sv
// Checker for bus handshake, flag clearing and overflow pulse spacing
`default_nettype none
module dtc_timer_sva
   import dtc_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [31:0]       readdata,
   input wire logic              waitrequest,
   input wire logic              unit0_vector_ack,
   input wire logic              unit1_vector_ack,
   input wire logic              ext_irq0_pin_n,
   input wire logic              unit0_overflow_flag,
   input wire logic              unit1_overflow_flag,
   input wire logic              ext_irq0_edge_flag,
   input wire logic              unit1_overflow_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire logic ctrl_wr = write && !waitrequest && address == REG_CTRL;

   a_wait_first: assert property ((read || write) && !$past(read || write)
      |-> waitrequest) else $error("request not held one cycle");
   a_wait_once: assert property ((read || write) && waitrequest ##1
      (read || write) |-> !waitrequest) else $error("wait too long");
   a_upper_zero: assert property (read && !waitrequest
      |-> readdata[31:8] == 24'h0) else $error("upper read bits set");
   a_unmapped_zero: assert property (read && !waitrequest
      && address > REG_U1_HI |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_read_hold: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
   a_pulse_gap: assert property (unit1_overflow_pulse
      |=> (!unit1_overflow_pulse) [*8]) else $error("overflow too soon");
   a_u0_clear: assert property ($fell(unit0_overflow_flag)
      |-> $past(unit0_vector_ack) || $past(ctrl_wr))
      else $error("unit 0 flag cleared without cause");
   a_u1_clear: assert property ($fell(unit1_overflow_flag)
      |-> $past(unit1_vector_ack) || $past(ctrl_wr))
      else $error("unit 1 flag cleared without cause");
   a_irq0_set: assert property ($rose(ext_irq0_edge_flag)
      |-> !$past(ext_irq0_pin_n) || !$past(ext_irq0_pin_n, 2)
      || $past(ctrl_wr)) else $error("edge flag set with pin high");
endmodule // dtc_timer_sva
bind dtc_timer dtc_timer_sva u_sva (.core_clk, .nrst, .address, .read,
   .write, .readdata, .waitrequest, .unit0_vector_ack, .unit1_vector_ack,
   .ext_irq0_pin_n, .unit0_overflow_flag, .unit1_overflow_flag,
   .ext_irq0_edge_flag, .unit1_overflow_pulse);
`default_nettype wire

//--- bench/dtc_pin_model.sv
// Event source driving the external count pins
`default_nettype none
module dtc_pin_model
(
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       en,
   input wire logic [7:0] hold,
   output logic           cnt_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] n;
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         n <= 8'h00;
         cnt_pin <= 1'b1;
      end
      else if (en)
      begin
         n <= (n + 8'h01 >= hold) ? 8'h00 : n + 8'h01;
         if (n + 8'h01 >= hold)
            cnt_pin <= !cnt_pin;
      end
   end
endmodule // dtc_pin_model
`default_nettype wire

//--- bench/dtc_timer_bench.sv
// Self-checking bench for the dual timer/counter
`default_nettype none
module dtc_timer_bench
   import dtc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic              core_clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] address = 5'h00;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata = 32'h0;
   logic              irq0_n = 1'b1;
   logic              u0_ack = 1'b0;
   logic              u1_ack = 1'b0;
   logic              i0_ack = 1'b0;
   logic              pin_en = 1'b0;
   logic              cnt_pin, waitrequest, u0_flag, u1_flag;
   logic              u1_pulse, e0_flag, e1_flag;
   int                n_pulse = 0;
   logic [31:0]       readdata, q;
   logic [15:0]       lfsr = 16'h0018;
   int                n_mismatch = 0;
   int                checks = 0;
   int                v, m, w;

   dtc_timer uut (.core_clk, .nrst, .address, .read, .write, .writedata,
      .byteenable(4'h1), .readdata, .waitrequest,
      .unit0_count_pin(cnt_pin), .unit1_count_pin(cnt_pin),
      .ext_irq0_pin_n(irq0_n), .ext_irq1_pin_n(irq0_n),
      .unit0_vector_ack(u0_ack), .unit1_vector_ack(u1_ack),
      .ext_irq0_vector_ack(i0_ack), .ext_irq1_vector_ack(1'b0),
      .unit0_overflow_flag(u0_flag), .unit1_overflow_flag(u1_flag),
      .ext_irq0_edge_flag(e0_flag), .ext_irq1_edge_flag(e1_flag),
      .unit1_overflow_pulse(u1_pulse));
   dtc_pin_model u_pins (.core_clk, .nrst, .en(pin_en), .hold(8'h0c),
      .cnt_pin);

   always #50 core_clk = ~core_clk;

   // Counts unit 1 overflow pulses for the baud-use check
   always @(posedge core_clk)
   begin
      if (u1_pulse === 1'b1)
      begin
         n_pulse <= n_pulse + 1;
      end
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Reference step of unit 0 as high*256+low; split steps both bytes
   function automatic int step(input int md, input int x);
      case (md)
         0: return (x % 32 == 31) ?
            ((x + 256) & 32'hff00) | (x & 32'he0) : x + 1;
         1: return (x + 1) % 65536;
         2: return (x % 256 == 255) ? (x & 32'hff00) | (x >> 8) : x + 1;
         default: return ((x / 256 + 1) % 256) * 256 + (x + 1) % 256;
      endcase
   endfunction

   task automatic tally_and_finish(input int extra);
      n_mismatch += extra;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; read data land in q
   task automatic bus(input logic [4:0] a, input logic wr,
      input logic [7:0] d);
      int i;
      @(posedge core_clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      i = 0;
      do
      begin
         @(posedge core_clk);
         i++;
      end
      while (waitrequest !== 1'b0 && i < 20);
      if (waitrequest !== 1'b0)
         tally_and_finish(1);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wait_flag(input int lim);
      int i;
      for (i = 0; i < lim && u0_flag !== 1'b1; i++)
         @(negedge core_clk);
      if (i == lim)
         tally_and_finish(1);
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      for (v = 0; v < 28; v += 4)
      begin
         bus(5'(v), 1'b0, 8'h00);
         chk(q, 32'h0);
         lfsr = lfsr_next(lfsr);
         bus(5'(v), 1'b1, (v == 0) ? 8'h00 : lfsr[7:0]);
         bus(5'(v), 1'b0, 8'h00);
         chk(q, (v % 24 == 0) ? 32'h0 : {24'h0, lfsr[7:0]});
      end
      $display("registers done");
      for (m = 0; m < 4; m++)
      begin
         w = (m == 2) ? 32'h80fe : ((m == 3) ? 32'hfefe : 32'hfffe);
         bus(REG_U0_LO, 1'b1, w[7:0]);
         bus(REG_U0_HI, 1'b1, w[15:8]);
         bus(REG_MODE, 1'b1, 8'(m));
         bus(REG_CTRL, 1'b1, (m == 3) ? 8'h50 : 8'h10);
         wait_flag(40);
         chk({31'h0, u1_flag}, 32'(m == 3));
         @(posedge core_clk);
         u0_ack <= 1'b1;
         u1_ack <= 1'b1;
         @(posedge core_clk);
         u0_ack <= 1'b0;
         u1_ack <= 1'b0;
         bus(REG_CTRL, 1'b0, 8'h00);
         chk(q, (m == 3) ? 32'h50 : 32'h10);
         bus(REG_CTRL, 1'b1, 8'h00);
         w = step(m, step(m, w));
         bus(REG_U0_LO, 1'b0, 8'h00);
         chk(q, w % 256);
         bus(REG_U0_HI, 1'b0, 8'h00);
         chk(q, w / 256);
      end
      $display("modes done");
      bus(REG_U0_LO, 1'b1, 8'h00);
      bus(REG_MODE, 1'b1, 8'h09);
      bus(REG_CTRL, 1'b1, 8'h11);
      irq0_n <= 1'b0;
      repeat (40) @(posedge core_clk);
      bus(REG_CTRL, 1'b0, 8'h00);
      chk(q, 32'h1b);
      chk({30'h0, e1_flag, e0_flag}, 32'h3);
      i0_ack <= 1'b1;
      @(posedge core_clk);
      i0_ack <= 1'b0;
      bus(REG_CTRL, 1'b0, 8'h00);
      chk(q, 32'h19);
      bus(REG_CTRL, 1'b1, 8'h10);
      repeat (30) @(posedge core_clk);
      bus(REG_CTRL, 1'b0, 8'h00);
      chk(q, 32'h1a);
      bus(REG_U0_LO, 1'b0, 8'h00);
      chk(q, 32'h0);
      irq0_n <= 1'b1;
      repeat (60) @(posedge core_clk);
      bus(REG_CTRL, 1'b1, 8'h00);
      bus(REG_U0_LO, 1'b0, 8'h00);
      v = int'(q);
      chk(32'(v > 2 && v < 10), 32'h1);
      bus(REG_CTRL, 1'b1, 8'h10);
      repeat (24) @(posedge core_clk);
      bus(REG_CTRL, 1'b1, 8'h00);
      bus(REG_U0_LO, 1'b0, 8'h00);
      chk(32'(q > v + 1 && q < v + 6), 32'h1);
      $display("gate done");
      bus(REG_U0_LO, 1'b1, 8'h00);
      bus(REG_MODE, 1'b1, 8'h05);
      pin_en <= 1'b1;
      bus(REG_CTRL, 1'b1, 8'h10);
      repeat (480) @(posedge core_clk);
      bus(REG_CTRL, 1'b1, 8'h00);
      bus(REG_U0_LO, 1'b0, 8'h00);
      chk(32'(q > 18 && q < 22), 32'h1);
      bus(REG_U1_LO, 1'b1, 8'h12);
      bus(REG_MODE, 1'b1, 8'h30);
      bus(REG_CTRL, 1'b1, 8'h40);
      repeat (40) @(posedge core_clk);
      bus(REG_U1_LO, 1'b0, 8'h00);
      chk(q, 32'h12);
      bus(REG_MODE, 1'b1, 8'h10);
      repeat (40) @(posedge core_clk);
      bus(REG_U1_LO, 1'b0, 8'h00);
      chk(32'(q > 32'h12), 32'h1);
      bus(REG_CTRL, 1'b1, 8'h00);
      bus(REG_U1_LO, 1'b1, 8'hfe);
      bus(REG_U1_HI, 1'b1, 8'hfd);
      v = n_pulse;
      bus(REG_MODE, 1'b1, 8'h23);
      repeat (40) @(posedge core_clk);
      chk(32'(n_pulse - v), 32'h1);
      chk({31'h0, u1_flag}, 32'h0);
      bus(REG_U1_LO, 1'b0, 8'h00);
      chk(32'(q == 32'hfe || q == 32'hff), 32'h1);
      $display("counter and unit 1 done");
      tally_and_finish(0);
   end
endmodule // dtc_timer_bench
`default_nettype wire
